//--- hdl/afic_consts.svh
`ifndef AFIC_CONSTS_SVH
`define AFIC_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AFIC_OFS_CH6_FILT   8'h33
`define AFIC_OFS_CH7_FILT   8'h34
`define AFIC_OFS_CH8_FILT   8'h35
`define AFIC_OFS_RATE       8'h38
`define AFIC_OFS_ILV        8'h40
`define AFIC_OFS_PHASE      8'h42
// ----------------------------------------
// Field positions
// ----------------------------------------
`define AFIC_HP_ON_BIT      14
`define AFIC_CORNER_HI      13
`define AFIC_CORNER_LO      10
`define AFIC_KIND_HI        9
`define AFIC_KIND_LO        7
`define AFIC_DEC_HI         6
`define AFIC_DEC_LO         4
`define AFIC_ODD_BIT        2
`define AFIC_PATH_BIT       0
`define AFIC_GATE_BIT       15
`define AFIC_PHASE_HI       6
`define AFIC_PHASE_LO       5
// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define AFIC_FILT_MASK      16'h7FF5
`define AFIC_RATE_MASK      16'h0003
`define AFIC_ILV_MASK       16'h80FF
`define AFIC_PHASE_MASK     16'h8060
`define AFIC_RESET_VAL      16'h0000
`define AFIC_ILV_ODD_VAL    16'h8000
`define AFIC_ILV_EVEN_VAL   16'h80FF
`define AFIC_SEL_EVEN       8'hFF
`endif

//--- hdl/afic_pkg.sv
package afic_pkg;
   // Decoded per-channel filter controls
   typedef struct packed {
      logic       highpass_on;
      logic [3:0] highpass_corner;
      logic [2:0] filter_kind;
      logic [2:0] decimation_factor;
      logic       odd_taps;
      logic       filter_path_on;
   } afic_filt_t;
   // Interleave pair selection
   typedef enum logic [1:0] {AFIC_ILV_NONE, AFIC_ILV_ODD, AFIC_ILV_EVEN, AFIC_ILV_CUSTOM} afic_ilv_t;
endpackage

//--- hdl/afic_filt_dec.sv
`timescale 1ns/10ps
`include "afic_consts.svh"
// ----------------------------------------
// Filter word field splitter
// ----------------------------------------
module afic_filt_dec
(
   input  wire logic [15:0]         word,  // Stored filter word
   output afic_pkg::afic_filt_t     flds   // Decoded fields
);
   // Pure slicing with no storage; the owner registers the result
   always_comb
   begin
      flds.highpass_on       = word[`AFIC_HP_ON_BIT];
      flds.highpass_corner   = word[`AFIC_CORNER_HI:`AFIC_CORNER_LO];
      flds.filter_kind       = word[`AFIC_KIND_HI:`AFIC_KIND_LO];
      flds.decimation_factor = word[`AFIC_DEC_HI:`AFIC_DEC_LO];
      flds.odd_taps          = word[`AFIC_ODD_BIT];
      flds.filter_path_on    = word[`AFIC_PATH_BIT];
   end
endmodule

//--- hdl/afic_regs.sv
// Function
// - Bit 14 enables channel high-pass filter
// - Bits 13:10 set high-pass corner
// - Bits 9:7 choose filter kind
// - Bits 6:4 set decimation factor
// - Bit 2 selects odd-tap filter variant
// - Bit 0 routes samples through filter
// - Rate register low two bits pick rate
// - Rate and phase registers reset to zero
// - Interleave selector acts only with bit 15
// - Value 8000 interleaves odd inputs
// - Value 80FF interleaves even inputs
// - Phase bit 15 gates phase field
// - Phase field sets bit clock phase
`timescale 1ns/10ps
`include "afic_consts.svh"
module afic_regs
(
   input  wire logic                 core_clk,          // 25 MHz clock
   input  wire logic                 rst,               // Synchronous reset, active high
   input  wire logic [7:0]           reg_addr,          // Register offset
   input  wire logic [15:0]          reg_wdata,         // Write data
   input  wire logic                 reg_wr,            // Write strobe
   input  wire logic                 reg_rd,            // Read strobe
   output logic      [15:0]          reg_rdata,         // Read data, cycle after strobe
   output afic_pkg::afic_filt_t      filt_chan6,        // Channel 6 filter controls
   output afic_pkg::afic_filt_t      filt_chan7,        // Channel 7 filter controls
   output afic_pkg::afic_filt_t      filt_chan8,        // Channel 8 filter controls
   output logic      [1:0]           output_rate,       // Output rate code
   output logic                      interleave_on,     // Odd/even selector in force
   output logic      [7:0]           interleave_sel,    // Effective selector
   output afic_pkg::afic_ilv_t       interleave_pair,   // Decoded pair choice
   output logic                      phase_prog_on,     // Phase programming in force
   output logic      [1:0]           serial_bit_clock_out_phase // Effective bit clock phase
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [15:0]          filt_q [3];            // Channel 6..8 filter words
   logic [15:0]          rate_q;                // Output rate word
   logic [15:0]          ilv_q;                 // Interleave word
   logic [15:0]          phase_q;               // Phase word
   logic [15:0]          rdata_d;               // Read mux result
   afic_pkg::afic_filt_t dec_w [3];             // Decoded filter fields

   // Offset of filter word index i
   function automatic logic [7:0] filt_ofs(input int i);
      filt_ofs = `AFIC_OFS_CH6_FILT + 8'(i);
   endfunction

   // Address hits the given offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   // ----------------------------------------
   // Filter words, one per channel
   // ----------------------------------------
   // Reserved bits are masked off so read-back stays clean even if software slips
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_filt
         always_ff @(posedge core_clk)
         begin
            if (rst)
               filt_q[gi] <= `AFIC_RESET_VAL;
            else if (reg_wr && hit(reg_addr, filt_ofs(gi)))
               filt_q[gi] <= reg_wdata & `AFIC_FILT_MASK;
         end
         afic_filt_dec u_dec
         (
            .word (filt_q[gi]),
            .flds (dec_w[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Rate register
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         rate_q <= `AFIC_RESET_VAL;
      else if (reg_wr && hit(reg_addr, `AFIC_OFS_RATE))
         rate_q <= reg_wdata & `AFIC_RATE_MASK;
   end

   // ----------------------------------------
   // Interleave register
   // ----------------------------------------
   // Zero at reset keeps the selector disabled until software sets it up
   always_ff @(posedge core_clk)
   begin
      if (rst)
         ilv_q <= `AFIC_RESET_VAL;
      else if (reg_wr && hit(reg_addr, `AFIC_OFS_ILV))
         ilv_q <= reg_wdata & `AFIC_ILV_MASK;
   end

   // ----------------------------------------
   // Phase register
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         phase_q <= `AFIC_RESET_VAL;
      else if (reg_wr && hit(reg_addr, `AFIC_OFS_PHASE))
         phase_q <= reg_wdata & `AFIC_PHASE_MASK;
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Unmapped offsets read zero
   always_comb
   begin
      rdata_d = 16'h0000;
      if (hit(reg_addr, `AFIC_OFS_CH6_FILT))
         rdata_d = filt_q[0];
      else if (hit(reg_addr, `AFIC_OFS_CH7_FILT))
         rdata_d = filt_q[1];
      else if (hit(reg_addr, `AFIC_OFS_CH8_FILT))
         rdata_d = filt_q[2];
      else if (hit(reg_addr, `AFIC_OFS_RATE))
         rdata_d = rate_q;
      else if (hit(reg_addr, `AFIC_OFS_ILV))
         rdata_d = ilv_q;
      else if (hit(reg_addr, `AFIC_OFS_PHASE))
         rdata_d = phase_q;
   end

   // Read data holds only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
         reg_rdata <= rdata_d;
      else
         reg_rdata <= 16'h0000;
   end

   // ----------------------------------------
   // Filter control outputs
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         filt_chan6 <= '0;
         filt_chan7 <= '0;
         filt_chan8 <= '0;
      end
      else
      begin
         filt_chan6 <= dec_w[0];
         filt_chan7 <= dec_w[1];
         filt_chan8 <= dec_w[2];
      end
   end

   // ----------------------------------------
   // Rate output
   // ----------------------------------------
   // Code meaning depends on filter kind, which the datapath resolves
   always_ff @(posedge core_clk)
   begin
      if (rst)
         output_rate <= 2'h0;
      else
         output_rate <= rate_q[1:0];
   end

   // ----------------------------------------
   // Interleave outputs
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         interleave_on   <= 1'b0;
         interleave_sel  <= 8'h00;
         interleave_pair <= afic_pkg::AFIC_ILV_NONE;
      end
      else
      begin
         interleave_on  <= ilv_q[`AFIC_GATE_BIT];
         interleave_sel <= ilv_q[`AFIC_GATE_BIT] ? ilv_q[7:0] : 8'h00;
         if (ilv_q == `AFIC_ILV_ODD_VAL)
            interleave_pair <= afic_pkg::AFIC_ILV_ODD;
         else if (ilv_q == `AFIC_ILV_EVEN_VAL)
            interleave_pair <= afic_pkg::AFIC_ILV_EVEN;
         else if (ilv_q[`AFIC_GATE_BIT])
            interleave_pair <= afic_pkg::AFIC_ILV_CUSTOM;
         else
            interleave_pair <= afic_pkg::AFIC_ILV_NONE;
      end
   end

   // ----------------------------------------
   // Bit clock phase outputs
   // ----------------------------------------
   // Gated field forced to zero so the serializer sees default phase when disabled
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         phase_prog_on              <= 1'b0;
         serial_bit_clock_out_phase <= 2'h0;
      end
      else
      begin
         phase_prog_on              <= phase_q[`AFIC_GATE_BIT];
         serial_bit_clock_out_phase <= phase_q[`AFIC_GATE_BIT] ?
                                       phase_q[`AFIC_PHASE_HI:`AFIC_PHASE_LO] : 2'h0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Rate code clears on reset
   a_rate_reset: assert property (@(posedge core_clk) rst |=> output_rate == 2'h0)
      else $error("rate not zero after reset");

   // Phase word clears on reset
   a_phase_reset: assert property (@(posedge core_clk) rst |=> phase_q == 16'h0000)
      else $error("phase word not zero after reset");

   // Word lands on the first edge, output on the second
   a_rate_write: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_RATE |=> ##1 output_rate == $past(reg_wdata[1:0], 2))
      else $error("rate output does not follow write");

   // High-pass enable of channel 6 follows its word
   a_hp_follow: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_CH6_FILT |=> ##1 filt_chan6.highpass_on == $past(reg_wdata[14], 2))
      else $error("high-pass enable mismatch");

   // Corner of channel 7 follows its word
   a_corner_follow: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_CH7_FILT |=> ##1 filt_chan7.highpass_corner == $past(reg_wdata[13:10], 2))
      else $error("corner mismatch");

   // Filter kind of channel 8 follows its word
   a_kind_follow: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_CH8_FILT |=> ##1 filt_chan8.filter_kind == $past(reg_wdata[9:7], 2))
      else $error("filter kind mismatch");

   // Decimation of channel 6 follows its word
   a_dec_follow: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_CH6_FILT |=> ##1 filt_chan6.decimation_factor == $past(reg_wdata[6:4], 2))
      else $error("decimation mismatch");

   // Odd-tap choice and filter path of channel 7 follow its word
   a_odd_follow: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_CH7_FILT |=> ##1 filt_chan7.odd_taps == $past(reg_wdata[2], 2) &&
      filt_chan7.filter_path_on == $past(reg_wdata[0], 2))
      else $error("odd tap or path mismatch");

   // Selector and pair stay idle while the gate is clear
   a_ilv_gate: assert property (@(posedge core_clk) disable iff (rst)
      !interleave_on |-> interleave_sel == 8'h00 && interleave_pair == afic_pkg::AFIC_ILV_NONE)
      else $error("selector active while gate clear");

   // Exact odd code picks the odd inputs
   a_ilv_odd: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_ILV && reg_wdata == `AFIC_ILV_ODD_VAL ##1 !reg_wr
      |=> interleave_pair == afic_pkg::AFIC_ILV_ODD)
      else $error("odd pair not selected");

   // Exact even code picks the even inputs
   a_ilv_even: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_ILV && reg_wdata == `AFIC_ILV_EVEN_VAL ##1 !reg_wr
      |=> interleave_pair == afic_pkg::AFIC_ILV_EVEN && interleave_sel == `AFIC_SEL_EVEN)
      else $error("even pair not selected");

   // Phase field has no effect while its gate is clear
   a_phase_gate: assert property (@(posedge core_clk) disable iff (rst)
      !phase_prog_on |-> serial_bit_clock_out_phase == 2'h0)
      else $error("phase active while gate clear");

   // Gated phase write reaches the bit clock phase output
   a_phase_follow: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_PHASE && reg_wdata[15] |=> ##1
      serial_bit_clock_out_phase == $past(reg_wdata[6:5], 2))
      else $error("phase field not applied");

   // Read straight after a write returns the new word
   a_readback: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == `AFIC_OFS_ILV ##1 reg_rd && reg_addr == `AFIC_OFS_ILV
      |=> reg_rdata == ($past(reg_wdata, 2) & `AFIC_ILV_MASK))
      else $error("read-back mismatch");

   // Read data is zero outside its slot
   a_rd_idle: assert property (@(posedge core_clk) disable iff (rst)
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read slot");

   // ----------------------------------------
   // Cover points
   // ----------------------------------------
   c_odd_pair: cover property (@(posedge core_clk) interleave_pair == afic_pkg::AFIC_ILV_ODD);
   c_even_pair: cover property (@(posedge core_clk) interleave_pair == afic_pkg::AFIC_ILV_EVEN);
   c_phase_on: cover property (@(posedge core_clk) phase_prog_on && serial_bit_clock_out_phase == 2'h3);
   c_filter_on: cover property (@(posedge core_clk) filt_chan8.filter_path_on && filt_chan8.highpass_on);
endmodule

//--- tb/test_afic_regs.sv
`timescale 1ns/10ps
`include "afic_consts.svh"
module test_afic_regs;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic                 core_clk;      // Bench clock, 40 ns
   logic                 rst;           // Synchronous reset
   logic [7:0]           reg_addr;      // Register offset
   logic [15:0]          reg_wdata;     // Write data
   logic                 reg_wr;        // Write strobe
   logic                 reg_rd;        // Read strobe
   logic [15:0]          reg_rdata;     // Read data
   afic_pkg::afic_filt_t filt_chan6;    // Channel 6 controls
   afic_pkg::afic_filt_t filt_chan7;    // Channel 7 controls
   afic_pkg::afic_filt_t filt_chan8;    // Channel 8 controls
   logic [1:0]           output_rate;   // Rate code
   logic                 interleave_on; // Selector gate
   logic [7:0]           interleave_sel; // Effective selector
   afic_pkg::afic_ilv_t  interleave_pair; // Pair choice
   logic                 phase_prog_on; // Phase gate
   logic [1:0]           bclk_phase;    // Effective phase
   logic [15:0]          exp_q[$];      // Expected read data, oldest first
   logic                 rd_pend = 1'b0; // Read data due this cycle
   logic [31:0]          seed;          // Random state
   logic [15:0]          fw[3];         // Last filter words written
   int                   err_count;     // Mismatches
   int                   n_checks;      // Comparisons
   int                   cyc = 0;       // Cycle counter for the hang limit
   afic_regs u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filt_chan6(filt_chan6),
      .filt_chan7(filt_chan7), .filt_chan8(filt_chan8), .output_rate(output_rate),
      .interleave_on(interleave_on), .interleave_sel(interleave_sel), .interleave_pair(interleave_pair),
      .phase_prog_on(phase_prog_on), .serial_bit_clock_out_phase(bclk_phase));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Galois shift register, fixed start so runs repeat
   function logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
   endfunction
   // Filter word to packed field order, reserved bits dropped
   function logic [15:0] fexp(input logic [15:0] w);
      return {3'h0, w[14], w[13:10], w[9:7], w[6:4], w[2], w[0]};
   endfunction
   // Automatic, since the read monitor and the main sequence both call it
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Bus master tasks
   // ----------------------------------------
   // wr and rd each own one edge, so back-to-back calls never double-assign
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
   endtask
   // Two idle edges let a write reach the control outputs
   task idle(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         reg_addr <= seed[7:0];
      end
      @(negedge core_clk);
   endtask
   task do_reset;
      @(posedge core_clk);
      rst <= 1'b1;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   // ----------------------------------------
   // Clock, hang limit and read monitor
   // ----------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      rd_pend <= reg_rd;
      if (cyc == 3000)
      begin
         err_count++;
         end_sim;
      end
   end
   // Read data stands one cycle only, and is zero otherwise
   always @(negedge core_clk)
   begin
      if (rd_pend && exp_q.size() == 0)
         chk(reg_rdata, 16'hDEAD);
      else if (rd_pend)
         chk(reg_rdata, exp_q.pop_front());
      else
         chk(reg_rdata, 16'h0000);
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   logic [15:0]         ilv_w[4] = '{16'h8000, 16'h80FF, 16'h00A5, 16'h80A5};
   logic [7:0]          ilv_s[4] = '{8'h00, 8'hFF, 8'h00, 8'hA5};
   afic_pkg::afic_ilv_t ilv_p[4] = '{afic_pkg::AFIC_ILV_ODD, afic_pkg::AFIC_ILV_EVEN,
                                     afic_pkg::AFIC_ILV_NONE, afic_pkg::AFIC_ILV_CUSTOM};
   logic [15:0]         ph_w[4]  = '{16'h0060, 16'h8040, 16'h8020, 16'h8060};
   logic [1:0]          ph_e[4]  = '{2'h0, 2'h2, 2'h1, 2'h3};
   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      seed = 32'h9D8E;
      err_count = 0;
      n_checks = 0;
      // All fields set, reserved bits clear
      fw = '{16'h7FF5, 16'h0000, 16'h0000};
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      // Reset values on filter, rate and phase registers and on rate, phase and interleave gate and pair outputs
      foreach (ilv_w[i]) rd(8'h33 + 8'(i), 16'h0000);
      rd(`AFIC_OFS_RATE, 16'h0000);
      rd(`AFIC_OFS_PHASE, 16'h0000);
      idle(2);
      chk({8'h00, output_rate, phase_prog_on, bclk_phase, interleave_on, 2'(interleave_pair)}, 16'h0000);
      // Filter words: all fields set first, then random, fields checked per channel
      for (int i = 0; i < 9; i++)
      begin
         if (i > 0)
            fw[i % 3] = seed[15:0] & `AFIC_FILT_MASK;
         wr(8'h33 + 8'(i % 3), fw[i % 3]);
         rd(8'h33 + 8'(i % 3), fw[i % 3]);
         seed = lfsr(seed);
         idle(2);
         chk({3'h0, filt_chan6}, fexp(fw[0]));
         chk({3'h0, filt_chan7}, fexp(fw[1]));
         chk({3'h0, filt_chan8}, fexp(fw[2]));
      end
      // Every rate code, reserved bits kept clear
      for (int c = 0; c < 4; c++)
      begin
         wr(`AFIC_OFS_RATE, {14'h0, 2'(c)});
         rd(`AFIC_OFS_RATE, {14'h0, 2'(c)});
         seed = lfsr(seed);
         idle(2);
         chk({14'h0, output_rate}, {14'h0, 2'(c)});
      end
      // Interleave selector with and without its gate
      foreach (ilv_w[i])
      begin
         wr(`AFIC_OFS_ILV, ilv_w[i]);
         rd(`AFIC_OFS_ILV, ilv_w[i]);
         idle(2);
         chk({15'h0, interleave_on}, {15'h0, ilv_w[i][15]});
         chk({8'h0, interleave_sel}, {8'h0, ilv_s[i]});
         chk({14'h0, interleave_pair}, {14'h0, ilv_p[i]});
      end
      // Bit clock phase with and without its gate
      foreach (ph_w[i])
      begin
         wr(`AFIC_OFS_PHASE, ph_w[i]);
         rd(`AFIC_OFS_PHASE, ph_w[i] & `AFIC_PHASE_MASK);
         idle(2);
         chk({15'h0, phase_prog_on}, {15'h0, ph_w[i][15]});
         chk({14'h0, bclk_phase}, {14'h0, ph_e[i]});
      end
      // Back to back, unmapped place refused, earlier word kept
      wr(`AFIC_OFS_CH7_FILT, 16'h5A51);
      rd(`AFIC_OFS_CH7_FILT, 16'h5A51);
      wr(8'h36, 16'hFFFF);
      rd(8'h36, 16'h0000);
      rd(`AFIC_OFS_CH6_FILT, fw[0] & `AFIC_FILT_MASK);
      idle(2);
      // Reset in mid-run clears rate and phase again
      do_reset;
      rd(`AFIC_OFS_RATE, 16'h0000);
      rd(`AFIC_OFS_PHASE, 16'h0000);
      idle(3);
      chk({14'h0, bclk_phase}, 16'h0000);
      chk({14'h0, output_rate}, 16'h0000);
      chk(16'(exp_q.size()), 16'h0000);
      end_sim;
   end
endmodule
